// ---- design/sws_scratch_cmd.sv ----
`timescale 1ns/1ps

// Contract
// - up to 32 devices, queryable by index
// - addresses learned at boot, returned on query
// - query answer starts with family code byte
// - erase clears conceal flag, fills ones
// - read slots return one during fill
// - alternating zero/one after fill completes
// - read sends address bytes then status
// - data follows from start byte offset
// - inverted crc after last data byte
// - ones after the crc
// - write stores data from start offset
// - partial final byte dropped, flag set
module sws_scratch_cmd (
  input  wire logic        core_clk_in,        // 100 mhz core clock
  input  wire logic        rst_n_in,           // synchronous reset, active low
  input  wire logic        bus_reset_in,       // bus reset pulse detected
  input  wire logic        wr_slot_in,         // master write slot, one cycle
  input  wire logic        wr_bit_in,          // bit value of that write slot
  input  wire logic        rd_slot_in,         // master sampled rd_bit_out
  output logic             rd_bit_out,         // bit for the next read slot
  input  wire logic        conceal_set_in,     // set scratch_conceal_flag
  output logic             conceal_out,        // scratch_conceal_flag
  output logic             partial_byte_out,   // partial_byte_flag
  input  wire logic        disc_valid_in,      // discovered address strobe
  input  wire logic [63:0] disc_addr_in,       // discovered address, family in [7:0]
  input  wire logic        disc_done_in,       // boot discovery finished
  input  wire logic        query_req_in,       // device information query
  input  wire logic [4:0]  query_idx_in,       // queried index
  output logic             query_valid_out,    // answer strobe
  output logic             query_present_out,  // index holds a device
  output logic [63:0]      query_addr_out,     // address, family code first byte
  output logic [5:0]       dev_count_out       // number of devices stored, at most 32
);

  ////////////////////////////////////////////////////////////////////////////
  // state record

  typedef struct packed {
    sws_pkg::sws_state_t state;     // handler state
    logic [31:0][63:0]   dev_tab;   // discovered addresses
    logic [5:0]          dev_cnt;   // entries filled
    logic                booting;   // discovery window open
    logic [31:0][7:0]    pad;       // scratchpad
    logic                conceal;   // scratch_conceal_flag
    logic                pf;        // partial_byte_flag
    logic [7:0]          cmd;       // latched command code
    logic [15:0]         ta;        // target_addr_high, target_addr_low
    logic [4:0]          end_off;   // end_byte_offset
    logic [4:0]          ptr;       // running byte offset
    logic [7:0]          sh;        // receive shifter, lsb first
    logic [2:0]          bc;        // received bits in shifter
    logic [15:0]         crc;       // running crc
    logic [15:0]         tx;        // transmit shifter, lsb first
    logic [3:0]          txc;       // transmit bits left minus one
    logic                hdr;       // second byte of a two byte phase
    logic [1:0]          hdr_i;     // header byte index
    logic [11:0]         timer;     // erase fill cycles
    logic                alt;       // completion pattern bit
    logic [3:0]          alt_cnt;   // completion bits read, saturating
    logic [63:0]         q_addr;    // query answer
    logic                q_present; // query hit
    logic                q_valid;   // query strobe
    logic                bit_r;     // registered read slot bit
  } sws_rec_t;

  sws_rec_t s_r;    // registered state
  sws_rec_t s_nxt;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one crc step, bit shifted in lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = fb ? ((c >> 1) ^ sws_pkg::CRC_POLY) : (c >> 1);
  endfunction

  // byte load into transmit shifter, idle ones above it
  function automatic logic [15:0] byte_load(input logic [7:0] b);
    byte_load = {sws_pkg::IDLE_BYTE, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [7:0]  byte_in;  // shifter with this slot's bit
    logic [15:0] crc_n;    // crc after this slot's bit
    byte_in = {wr_bit_in, s_r.sh[7:1]};
    crc_n   = crc_step(s_r.crc, wr_bit_in);
    s_nxt   = s_r;
    s_nxt.q_valid = 1'b0;

    // boot discovery fills the table in order
    if (s_r.booting && disc_valid_in && (s_r.dev_cnt < 6'(sws_pkg::MAX_DEV)))
    begin
      s_nxt.dev_tab[s_r.dev_cnt[4:0]] = disc_addr_in;
      s_nxt.dev_cnt = s_r.dev_cnt + 6'h01;
    end
    if (disc_done_in)
      s_nxt.booting = 1'b0;

    // query by index, family code in the low byte
    if (query_req_in)
    begin
      s_nxt.q_valid   = 1'b1;
      s_nxt.q_addr    = s_r.dev_tab[query_idx_in];
      s_nxt.q_present = {1'b0, query_idx_in} < s_r.dev_cnt;
    end

    if (bus_reset_in)
    begin
      // any state returns to command reception
      if (s_r.state == sws_pkg::ST_WDATA && s_r.bc != 3'h0)
        s_nxt.pf = 1'b1;  // incomplete last byte discarded
      s_nxt.state = sws_pkg::ST_CMD;
      s_nxt.bc    = 3'h0;
      s_nxt.hdr   = 1'b0;
      s_nxt.crc   = sws_pkg::CRC_INIT;
    end
    else
    begin
      // write slots feed the receive path only where bytes are expected
      if (wr_slot_in && (s_r.state == sws_pkg::ST_CMD || s_r.state == sws_pkg::ST_TA
                         || s_r.state == sws_pkg::ST_WDATA))
      begin
        s_nxt.sh  = byte_in;
        s_nxt.bc  = s_r.bc + 3'h1;
        s_nxt.crc = crc_n;
        if (s_r.bc == 3'h7)
        begin
          case (s_r.state)
            sws_pkg::ST_CMD:
            begin
              s_nxt.cmd = byte_in;
              if (byte_in == sws_pkg::CMD_ERASE || byte_in == sws_pkg::CMD_WRITE)
                s_nxt.state = sws_pkg::ST_TA;
              else if (byte_in == sws_pkg::CMD_READ && !s_r.conceal)
              begin
                // address low, address high, then status
                s_nxt.state = sws_pkg::ST_RD_HDR;
                s_nxt.tx    = byte_load(s_r.ta[7:0]);
                s_nxt.txc   = 4'h7;
                s_nxt.hdr_i = 2'h0;
                s_nxt.ptr   = s_r.ta[4:0];
              end
              else
                s_nxt.state = sws_pkg::ST_DEAF;  // unsupported code or concealed read, stay silent
            end
            sws_pkg::ST_TA:
            begin
              s_nxt.hdr = ~s_r.hdr;
              if (!s_r.hdr)
                s_nxt.ta[7:0] = byte_in;
              else
              begin
                s_nxt.ta[15:8] = byte_in;
                // erase takes no data after the address
                if (s_r.cmd == sws_pkg::CMD_ERASE)
                begin
                  // fill ignores the target address
                  s_nxt.state   = sws_pkg::ST_FILL;
                  s_nxt.pad     = {sws_pkg::PAD_BYTES{sws_pkg::FILL_BYTE}};
                  s_nxt.conceal = 1'b0;
                  s_nxt.timer   = 12'h000;
                end
                else
                begin
                  s_nxt.state = sws_pkg::ST_WDATA;
                  s_nxt.ptr   = s_r.ta[4:0];
                  s_nxt.pf    = 1'b0;
                end
              end
            end
            sws_pkg::ST_WDATA:
            begin
              // only complete bytes reach the scratchpad
              s_nxt.pad[s_r.ptr] = byte_in;
              s_nxt.end_off      = s_r.ptr;
              if (s_r.ptr == sws_pkg::LAST_OFF)
              begin
                // full scratchpad: crc may be read back
                s_nxt.state = sws_pkg::ST_WR_CRC;
                s_nxt.tx    = ~crc_n;
                s_nxt.txc   = 4'hf;
              end
              else
                s_nxt.ptr = s_r.ptr + 5'h01;
            end
            default:
              s_nxt.state = s_r.state;
          endcase
        end
      end

      // read slots consume the bit that was on offer
      if (rd_slot_in)
      begin
        case (s_r.state)
          sws_pkg::ST_RD_HDR, sws_pkg::ST_RD_DATA, sws_pkg::ST_RD_CRC, sws_pkg::ST_WR_CRC:
          begin
            crc_n      = crc_step(s_r.crc, s_r.tx[0]);
            s_nxt.tx   = {1'b1, s_r.tx[15:1]};
            s_nxt.txc  = s_r.txc - 4'h1;
            if (s_r.state == sws_pkg::ST_RD_HDR || s_r.state == sws_pkg::ST_RD_DATA)
              s_nxt.crc = crc_n;
            if (s_r.txc == 4'h0)
            begin
              if (s_r.state == sws_pkg::ST_RD_HDR)
              begin
                s_nxt.hdr_i = s_r.hdr_i + 2'h1;
                if (s_r.hdr_i == 2'h0)
                  s_nxt.tx = byte_load(s_r.ta[15:8]);
                else if (s_r.hdr_i == 2'h1)
                  s_nxt.tx = byte_load({2'b00, s_r.pf, s_r.end_off});
                else
                begin
                  // data from the start offset
                  s_nxt.state = sws_pkg::ST_RD_DATA;
                  s_nxt.tx    = byte_load(s_r.pad[s_r.ptr]);
                end
                s_nxt.txc = 4'h7;
              end
              else if (s_r.state == sws_pkg::ST_RD_DATA)
              begin
                if (s_r.ptr == sws_pkg::LAST_OFF)
                begin
                  // crc covers command through last data bit
                  s_nxt.state = sws_pkg::ST_RD_CRC;
                  s_nxt.tx    = ~crc_n;
                  s_nxt.txc   = 4'hf;
                end
                else
                begin
                  s_nxt.ptr = s_r.ptr + 5'h01;
                  s_nxt.tx  = byte_load(s_r.pad[s_r.ptr + 5'h01]);
                  s_nxt.txc = 4'h7;
                end
              end
              else
                s_nxt.state = sws_pkg::ST_ONES;  // crc done, ones follow
            end
          end
          sws_pkg::ST_DONE:
          begin
            // completion pattern toggles per slot
            s_nxt.alt = ~s_r.alt;
            if (s_r.alt_cnt != sws_pkg::ALT_MIN_BITS)
              s_nxt.alt_cnt = s_r.alt_cnt + 4'h1;  // counts toward the eight
          end
          default:
            s_nxt.alt = s_r.alt;
        endcase
      end

      // fill duration, slots read ones meanwhile
      if (s_r.state == sws_pkg::ST_FILL)
      begin
        if (s_r.timer == sws_pkg::ERASE_LAST)
        begin
          s_nxt.state   = sws_pkg::ST_DONE;
          s_nxt.alt     = 1'b0;
          s_nxt.alt_cnt = 4'h0;
        end
        else
          s_nxt.timer = s_r.timer + 12'h001;
      end
    end

    // set from the authentication side wins over the erase clear
    if (conceal_set_in)
      s_nxt.conceal = 1'b1;

    // bit on offer for the next read slot
    case (s_nxt.state)
      sws_pkg::ST_RD_HDR, sws_pkg::ST_RD_DATA, sws_pkg::ST_RD_CRC, sws_pkg::ST_WR_CRC:
        s_nxt.bit_r = s_nxt.tx[0];
      sws_pkg::ST_DONE:
        s_nxt.bit_r = s_nxt.alt;
      default:
        s_nxt.bit_r = 1'b1;  // idle line, fill, crc tail, deaf
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // whole record registered; reset keeps the table empty
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      s_r         <= '0;
      s_r.state   <= sws_pkg::ST_CMD;
      s_r.booting <= 1'b1;
      s_r.bit_r   <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign rd_bit_out        = s_r.bit_r;
  assign conceal_out       = s_r.conceal;
  assign partial_byte_out  = s_r.pf;
  assign query_valid_out   = s_r.q_valid;
  assign query_present_out = s_r.q_present;
  assign query_addr_out    = s_r.q_addr;
  assign dev_count_out     = s_r.dev_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_fill_end;
    s_r.state == sws_pkg::ST_FILL && s_r.timer == sws_pkg::ERASE_LAST && !bus_reset_in;
  endsequence

  property p_query;
    query_req_in |=> query_valid_out && query_addr_out[7:0] == $past(s_r.dev_tab[query_idx_in][7:0]);
  endproperty
  a_query: assert property (p_query) else $error("query answer wrong");

  property p_disc;
    s_r.booting && disc_valid_in && s_r.dev_cnt < 6'h20 |=> dev_count_out == $past(s_r.dev_cnt) + 6'h01;
  endproperty
  a_disc: assert property (p_disc) else $error("discovery not stored");

  property p_erase_fill;
    s_r.state == sws_pkg::ST_TA && s_nxt.state == sws_pkg::ST_FILL && !conceal_set_in
      |=> !conceal_out && s_r.pad == {sws_pkg::PAD_BYTES{sws_pkg::FILL_BYTE}};
  endproperty
  a_erase_fill: assert property (p_erase_fill) else $error("erase fill wrong");

  property p_fill_ones;
    s_r.state == sws_pkg::ST_FILL |-> rd_bit_out;
  endproperty
  a_fill_ones: assert property (p_fill_ones) else $error("fill not ones");

  property p_fill_end;
    s_fill_end |=> s_r.state == sws_pkg::ST_DONE && !rd_bit_out;
  endproperty
  a_fill_end: assert property (p_fill_end) else $error("fill end wrong");

  property p_alt;
    s_r.state == sws_pkg::ST_DONE && rd_slot_in && !bus_reset_in |=> rd_bit_out != $past(rd_bit_out);
  endproperty
  a_alt: assert property (p_alt) else $error("pattern not alternating");

  property p_read_start;
    s_r.state == sws_pkg::ST_CMD && wr_slot_in && s_r.bc == 3'h7 && !bus_reset_in
      && {wr_bit_in, s_r.sh[7:1]} == sws_pkg::CMD_READ && !s_r.conceal
      |=> s_r.state == sws_pkg::ST_RD_HDR && rd_bit_out == s_r.ta[0] && s_r.ptr == s_r.ta[4:0];
  endproperty
  a_read_start: assert property (p_read_start) else $error("read start wrong");

  property p_crc_next;
    s_r.state == sws_pkg::ST_RD_DATA && s_r.ptr == sws_pkg::LAST_OFF && s_r.txc == 4'h0
      && rd_slot_in && !bus_reset_in |=> s_r.state == sws_pkg::ST_RD_CRC;
  endproperty
  a_crc_next: assert property (p_crc_next) else $error("crc not sent");

  property p_ones;
    s_r.state == sws_pkg::ST_ONES && !bus_reset_in |=> rd_bit_out && s_r.state == sws_pkg::ST_ONES;
  endproperty
  a_ones: assert property (p_ones) else $error("tail not ones");

  property p_write;
    s_r.state == sws_pkg::ST_WDATA && wr_slot_in && s_r.bc == 3'h7 && !bus_reset_in
      |=> s_r.pad[$past(s_r.ptr)] == $past({wr_bit_in, s_r.sh[7:1]});
  endproperty
  a_write: assert property (p_write) else $error("write not stored");

  property p_partial;
    s_r.state == sws_pkg::ST_WDATA && s_r.bc != 3'h0 && bus_reset_in |=> partial_byte_out;
  endproperty
  a_partial: assert property (p_partial) else $error("partial flag missed");

endmodule

// ---- include/sws_pkg.sv ----
package sws_pkg;

  // command codes seen on the bus, and the fill and idle byte values
  localparam logic [7:0]  CMD_ERASE     = 8'hc3;   // clear conceal flag, fill scratchpad
  localparam logic [7:0]  CMD_READ      = 8'haa;   // read back address, status, data, crc
  localparam logic [7:0]  CMD_WRITE     = 8'h0f;   // store data at target offset
  localparam logic [7:0]  FILL_BYTE     = 8'hff;   // erase fill value
  localparam logic [7:0]  IDLE_BYTE     = 8'hff;   // line idles high, read slots return ones

  // sizes
  localparam int          MAX_DEV       = 32;      // enumerated bus devices
  localparam int          PAD_BYTES     = 32;      // scratchpad depth
  localparam logic [4:0]  LAST_OFF      = 5'h1f;   // last scratchpad offset
  localparam logic [3:0]  ALT_MIN_BITS  = 4'h8;    // completion bits the master must read

  // crc-16 as shifted lsb first, reflected polynomial
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam logic [15:0] CRC_INIT      = 16'h0000;

  // erase fill duration
  localparam int          CLK_PERIOD_NS = 10;      // 100 mhz core clock
  localparam int          ERASE_TIME_NS = 32000;   // about 32 us
  localparam int          ERASE_CYC     = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [11:0] ERASE_LAST    = 12'(ERASE_CYC - 1);

  // field layout of the end-offset / status byte
  localparam int          ES_PF_BIT     = 5;       // partial byte flag position

  // command handler states, one-hot
  typedef enum logic [9:0] {
    ST_CMD      = 10'h001,  // receiving command code
    ST_TA       = 10'h002,  // receiving target address
    ST_WDATA    = 10'h004,  // receiving write data
    ST_WR_CRC   = 10'h008,  // sending inverted crc after a full write
    ST_FILL     = 10'h010,  // erase fill running
    ST_DONE     = 10'h020,  // erase complete, alternating pattern
    ST_RD_HDR   = 10'h040,  // sending address and status bytes
    ST_RD_DATA  = 10'h080,  // sending scratchpad data
    ST_RD_CRC   = 10'h100,  // sending inverted crc
    ST_ONES     = 10'h200   // all ones until bus reset
  } sws_state_t;

  // deaf state for unsupported commands shares the ones encoding of the line
  localparam sws_state_t ST_DEAF = ST_ONES;

endpackage

// ---- sim/sws_bus_master.sv ----
`timescale 1ns/1ps

// slot-level model of the bus master on the far side of the line
module sws_bus_master (
  input  wire logic clk_in,        // core clock
  output logic      bus_reset_out, // bus reset pulse
  output logic      wr_slot_out,   // write slot pulse
  output logic      wr_bit_out,    // value of the write slot
  output logic      rd_slot_out,   // read slot pulse
  input  wire logic rd_bit_in      // bit offered by the slave
);
  int gap = 0; // idle cycles before each slot, nonzero for a slow master

  // quiet line at time zero
  initial
  begin
    bus_reset_out = 1'b0;
    wr_slot_out   = 1'b0;
    wr_bit_out    = 1'b0;
    rd_slot_out   = 1'b0;
  end

  // slow masters leave idle cycles between slots
  task automatic idle();
    repeat (gap) @(posedge clk_in);
  endtask

  task automatic line_reset();
    idle();
    @(posedge clk_in);
    bus_reset_out <= 1'b1;
    @(posedge clk_in);
    bus_reset_out <= 1'b0;
  endtask

  task automatic wbit(input logic b);
    idle();
    @(posedge clk_in);
    wr_slot_out <= 1'b1;
    wr_bit_out  <= b;
    @(posedge clk_in);
    wr_slot_out <= 1'b0;
    wr_bit_out  <= ~b; // released: the old value must not linger
  endtask

  // bytes go out lsb first
  task automatic wbyte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) wbit(v[i]);
  endtask

  // sample mid-cycle so the offered bit has settled
  task automatic rbit(output logic b);
    idle();
    @(posedge clk_in);
    rd_slot_out <= 1'b1;
    @(negedge clk_in);
    b = rd_bit_in;
    @(posedge clk_in);
    rd_slot_out <= 1'b0;
  endtask

  task automatic rbyte(output logic [7:0] v);
    logic b;
    for (int i = 0; i < 8; i++)
    begin
      rbit(b);
      v[i] = b;
    end
  endtask
endmodule

// ---- sim/test_single_wire_scratchpad_cmd.sv ----
`timescale 1ns/1ps

module test_single_wire_scratchpad_cmd;
  logic        clk = 1'b0;                 // 100 mhz core clock
  logic        rst_n, bus_reset, wr_slot;  // reset and master strobes
  logic        wr_bit, rd_slot, rd_bit;    // bit link
  logic        conceal_set, conceal, partial_byte;
  logic        disc_valid, disc_done, query_req, query_valid, query_present;
  logic [63:0] disc_addr, query_addr;      // boot addresses and answers
  logic [4:0]  query_idx;
  logic [5:0]  dev_count;
  int          bad_count = 0;
  int          checks = 0;
  int          n;
  logic [15:0] rnd = 16'h16a3;             // lfsr seed
  logic [15:0] crc;                        // running expected crc
  logic [15:0] c;
  logic [7:0]  pad [32];                   // expected scratchpad
  logic [63:0] dev [33];                   // one more than the table holds
  logic [7:0]  tal, tah, v;
  logic        b;

  always #5 clk = ~clk;

  sws_scratch_cmd u_sws_scratch_cmd (
    .core_clk_in(clk), .rst_n_in(rst_n), .bus_reset_in(bus_reset),
    .wr_slot_in(wr_slot), .wr_bit_in(wr_bit), .rd_slot_in(rd_slot), .rd_bit_out(rd_bit),
    .conceal_set_in(conceal_set), .conceal_out(conceal), .partial_byte_out(partial_byte),
    .disc_valid_in(disc_valid), .disc_addr_in(disc_addr), .disc_done_in(disc_done),
    .query_req_in(query_req), .query_idx_in(query_idx), .query_valid_out(query_valid),
    .query_present_out(query_present), .query_addr_out(query_addr),
    .dev_count_out(dev_count));

  sws_bus_master u_sws_bus_master (
    .clk_in(clk), .bus_reset_out(bus_reset), .wr_slot_out(wr_slot),
    .wr_bit_out(wr_bit), .rd_slot_out(rd_slot), .rd_bit_in(rd_bit));

  ////////////////////////////////////////////////////////////////////////////
  // random source, crc model, compare and verdict
  function automatic logic [15:0] rnd16();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction

  function automatic logic [7:0] rnd8();
    logic [15:0] t;
    t = rnd16();
    return t[7:0];
  endfunction

  // reflected crc16, lsb first, as the slave shifts it
  function automatic logic [15:0] crc_add(input logic [15:0] c0, input logic [7:0] d);
    logic [15:0] r;
    r = c0 ^ {8'h00, d};
    for (int k = 0; k < 8; k++) r = r[0] ? ((r >> 1) ^ sws_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction

  task automatic close_out();
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // every byte on the line also feeds the expected crc
  task automatic send(input logic [7:0] d);
    u_sws_bus_master.wbyte(d);
    crc = crc_add(crc, d);
  endtask

  task automatic rd_expect(input logic [7:0] exp);
    logic [7:0] got;
    u_sws_bus_master.rbyte(got);
    chk(got, exp);
    crc = crc_add(crc, exp);
  endtask

  task automatic start(input logic [7:0] cmd, input logic [4:0] off);
    v = rnd8();
    tal = {v[7:5], off};
    tah = {7'h00, v[0]};
    crc = sws_pkg::CRC_INIT;
    u_sws_bus_master.line_reset();
    send(cmd);
    send(tal);
    send(tah);
  endtask

  // full write up to the last offset, then read it all back
  task automatic write_then_read(input logic [4:0] off);
    start(sws_pkg::CMD_WRITE, off);
    for (int i = off; i < 32; i++)
    begin
      pad[i] = rnd8();
      send(pad[i]);
    end
    c = ~crc;
    rd_expect(c[7:0]);
    rd_expect(c[15:8]);
    crc = crc_add(sws_pkg::CRC_INIT, sws_pkg::CMD_READ);
    u_sws_bus_master.line_reset();
    u_sws_bus_master.wbyte(sws_pkg::CMD_READ);
    rd_expect(tal);
    rd_expect(tah);
    rd_expect({3'b000, sws_pkg::LAST_OFF});
    for (int i = off; i < 32; i++) rd_expect(pad[i]);
    c = ~crc;
    rd_expect(c[7:0]);
    rd_expect(c[15:8]);
    rd_expect(8'hff);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst_n, conceal_set, disc_valid, disc_done, query_req} = '0;
    disc_addr = '0;
    query_idx = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(rd_bit, 1'b1);
    chk(dev_count, 6'h00);
    // empty table: any index answers absent
    @(posedge clk);
    query_req <= 1'b1;
    query_idx <= 5'(rnd8());
    @(posedge clk);
    query_req <= 1'b0;
    @(negedge clk);
    chk(query_valid, 1'b1);
    chk(query_present, 1'b0);
    // boot discovery offers 33 addresses, the table keeps 32
    for (int i = 0; i < 33; i++)
    begin
      dev[i] = {rnd16(), rnd16(), rnd16(), rnd16()};
      @(posedge clk);
      disc_valid <= 1'b1;
      disc_addr  <= dev[i];
      @(posedge clk);
      disc_valid <= 1'b0;
      disc_addr  <= ~dev[i];
    end
    @(posedge clk);
    disc_done <= 1'b1;
    @(posedge clk);
    disc_done <= 1'b0;
    @(negedge clk);
    chk(dev_count, 6'h20);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk);
      query_req <= 1'b1;
      query_idx <= 5'(i);
      @(posedge clk);
      query_req <= 1'b0;
      @(negedge clk);
      chk(query_valid, 1'b1);
      chk(query_present, 1'b1);
      chk(query_addr, dev[i]);
      chk(query_addr[7:0], dev[i][7:0]);
    end
    // prompt master at a random offset, slow master at the last offset
    write_then_read(5'(rnd8()));
    u_sws_bus_master.gap = 2;
    write_then_read(sws_pkg::LAST_OFF);
    u_sws_bus_master.gap = 0;
    // partial final byte, cut short by a bus reset
    start(sws_pkg::CMD_WRITE, 5'h03);
    send(rnd8());
    @(negedge clk);
    chk(partial_byte, 1'b0);
    for (int i = 0; i < 3; i++) u_sws_bus_master.wbit(rnd[i]);
    u_sws_bus_master.line_reset();
    @(negedge clk);
    chk(partial_byte, 1'b1);
    // erase clears the concealment flag and fills the scratchpad
    @(posedge clk);
    conceal_set <= 1'b1;
    @(posedge clk);
    conceal_set <= 1'b0;
    @(negedge clk);
    chk(conceal, 1'b1);
    // read refused while concealed: line stays high
    u_sws_bus_master.line_reset();
    u_sws_bus_master.wbyte(sws_pkg::CMD_READ);
    rd_expect(8'hff);
    start(sws_pkg::CMD_ERASE, 5'(rnd8()));
    @(negedge clk);
    chk(conceal, 1'b0);
    n = 0;
    u_sws_bus_master.rbit(b);
    while (b === 1'b1 && n < 2000)
    begin
      n++;
      u_sws_bus_master.rbit(b);
    end
    if (n >= 2000)
    begin
      bad_count++;
      close_out();
    end
    chk(n >= sws_pkg::ERASE_CYC / 2 - 10 && n <= sws_pkg::ERASE_CYC / 2 + 10, 1'b1);
    v[0] = b;
    for (int i = 1; i < 8; i++)
    begin
      u_sws_bus_master.rbit(b);
      v[i] = b;
    end
    chk(v, 8'haa);
    rd_expect(8'haa);
    u_sws_bus_master.line_reset();
    u_sws_bus_master.wbyte(sws_pkg::CMD_READ);
    rd_expect(tal);
    rd_expect(tah);
    rd_expect({2'b00, 1'b1, 5'h03});
    for (int i = tal[4:0]; i < 32; i++) rd_expect(sws_pkg::FILL_BYTE);
    // unsupported code leaves the slave silent until the next bus reset
    u_sws_bus_master.line_reset();
    u_sws_bus_master.wbyte(8'h3c);
    rd_expect(8'hff);
    u_sws_bus_master.wbyte(sws_pkg::CMD_READ);
    rd_expect(8'hff);
    u_sws_bus_master.line_reset();
    u_sws_bus_master.wbyte(sws_pkg::CMD_READ);
    rd_expect(tal);
    close_out();
  end
endmodule
